// >>> logic/usb_device_end.sv
// Added by the designer: the Wishbone slave port.
`include "usb_regs_map.svh"
`timescale 1ns/100ps
module usb_device_end #(
   parameter int SUSPEND_CYC = `SUSPEND_US * 1000 / `CLK_PERIOD_NS,
   parameter int REMOTE_IDLE_CYC = `REMOTE_IDLE_US * 1000 / `CLK_PERIOD_NS,
   parameter int RESUME_CYC = `RESUME_US * 1000 / `CLK_PERIOD_NS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   usb_link_if.dev link
);
   localparam int RESET_CYC = (`BUS_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int RW = $clog2(RESUME_CYC + 1);

   logic [1:0] dp_s_r;
   logic [1:0] dm_s_r;
   usb_link_pkg::line_t line;
   logic se0;
   logic jst;
   logic in_reset;
   logic in_reset_q_r;
   logic idle3;
   logic idle3_q_r;
   logic idle5;
   logic reset_start;
   logic reset_end;
   logic acc;
   logic [7:0] idx;
   logic [7:0] wd;
   logic wr_ctl;
   logic wr_flags;
   logic wr_en;
   logic wr_fclr;
   logic wr_aux;
   logic send_wake_r;
   logic detach_r;
   logic rwe_r;
   logic config_r;
   logic addr_en_r;
   logic clk_stop_r;
   logic suspended_r;
   logic [7:0] flags_r;
   logic [7:0] en_r;
   logic [7:0] ev_set;
   logic [7:0] ev_clr;
   usb_link_pkg::resume_state_t rs_state_r;
   logic rs_done_r;
   logic [RW-1:0] rs_cnt_r;
   logic resume_active;
   logic own_resume;
   logic [1:0] own_k_r;
   logic wr_acc;
   logic drive_oe_n_r;
   logic vref_oe_n_r;

   // Line pins pass two flip-flops before use.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dp_s_r <= 2'b00;
         dm_s_r <= 2'b00;
      end else begin
         dp_s_r <= {dp_s_r[0], link.bus_dp};
         dm_s_r <= {dm_s_r[0], link.bus_dm};
      end
   end

   assign line = usb_link_pkg::line_of(dp_s_r[1], dm_s_r[1]);
   assign se0 = (line == usb_link_pkg::LINE_SE0);
   assign jst = (line == usb_link_pkg::LINE_J);

   condition_timer #(.LIMIT(RESET_CYC)) u_reset_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cond_i(se0),
      .reached_o(in_reset)
   );

   condition_timer #(.LIMIT(SUSPEND_CYC)) u_suspend_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cond_i(jst),
      .reached_o(idle3)
   );

   condition_timer #(.LIMIT(REMOTE_IDLE_CYC)) u_wake_idle_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cond_i(jst),
      .reached_o(idle5)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_reset_q_r <= 1'b0;
         idle3_q_r <= 1'b0;
      end else begin
         in_reset_q_r <= in_reset;
         idle3_q_r <= idle3;
      end
   end

   assign reset_start = in_reset && !in_reset_q_r;
   assign reset_end = !in_reset && in_reset_q_r;

   // Wishbone decode; every access is answered one cycle later.
   assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign idx = wb_adr_i[9:2];
   assign wd = wb_dat_i[7:0];
   // Writes land at the edge where the master samples ack high.
   assign wr_acc = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
   assign wr_ctl = wr_acc && (idx == `IDX_CONTROL);
   assign wr_flags = wr_acc && (idx == `IDX_FLAGS);
   assign wr_en = wr_acc && (idx == `IDX_ENABLES);
   assign wr_fclr = wr_acc && (idx == `IDX_FLAG_CLEAR);
   assign wr_aux = wr_acc && (idx == `IDX_AUX);

   function automatic logic [7:0] rd_byte(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         `IDX_CONTROL: begin
            v[`CTL_SEND_WAKE] = send_wake_r;
            v[`CTL_DETACH] = detach_r;
            v[`CTL_RESUME_ACTIVE] = resume_active;
            v[`CTL_RWE] = rwe_r;
            v[`CTL_CONFIG] = config_r;
            v[`CTL_ADDR_EN] = addr_en_r;
         end
         `IDX_FLAGS: v = flags_r & `EV_MASK;
         `IDX_ENABLES: v = en_r & `EV_MASK;
         `IDX_AUX: begin
            v[`AUX_CLK_STOP] = clk_stop_r;
            v[`AUX_SUSPENDED] = suspended_r;
            v[`AUX_IN_RESET] = in_reset;
         end
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= acc;
         if (acc && !wb_we_i) begin
            wb_dat_o <= {24'h00_0000, rd_byte(idx)};
         end
      end
   end

   // Control bits written by software; bus reset clears only config_r and addr_en_r.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         send_wake_r <= 1'b0;
         detach_r <= 1'b0;
         rwe_r <= 1'b0;
         clk_stop_r <= 1'b0;
      end else begin
         if (wr_ctl) begin
            send_wake_r <= wd[`CTL_SEND_WAKE];
            detach_r <= wd[`CTL_DETACH];
            rwe_r <= wd[`CTL_RWE];
         end
         if (wr_aux) begin
            clk_stop_r <= wd[`AUX_CLK_STOP];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         config_r <= 1'b0;
         addr_en_r <= 1'b0;
      end else if (reset_start) begin
         config_r <= 1'b0;
         addr_en_r <= 1'b0;
      end else if (wr_ctl) begin
         config_r <= wd[`CTL_CONFIG];
         addr_en_r <= addr_en_r | wd[`CTL_ADDR_EN];
      end
   end

   // Pull-up reference floats while detached.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vref_oe_n_r <= 1'b0;
      end else begin
         vref_oe_n_r <= detach_r;
      end
   end

   assign link.vref = 1'b1;
   assign link.vref_oe_n = vref_oe_n_r;

   // Event sources; a set in the same cycle as a clear wins.
   always_comb begin
      ev_set = 8'h00;
      ev_set[`EV_WAKE] = suspended_r && !jst && !own_resume;
      ev_set[`EV_EOR] = reset_end;
      ev_set[`EV_SOF] = link.tok_valid && (link.tok_pid == `PID_SOF);
      ev_set[`EV_SUSP] = idle3 && !idle3_q_r;
      ev_clr = 8'h00;
      if (wr_flags) begin
         ev_clr = ~wd;
      end
      if (wr_fclr) begin
         ev_clr = ev_clr | wd;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_r <= `FLAGS_RESET;
      end else begin
         flags_r <= ((flags_r & ~ev_clr) | ev_set) & `EV_MASK;
      end
   end

   // Suspend lasts until software clears the suspend flag or a bus reset starts.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         suspended_r <= 1'b0;
      end else if (ev_set[`EV_SUSP]) begin
         suspended_r <= 1'b1;
      end else if (ev_clr[`EV_SUSP] || reset_start) begin
         suspended_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_r <= `ENABLES_RESET;
      end else if (wr_en) begin
         en_r <= wd & `EV_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(flags_r & en_r);
      end
   end

   // Upstream resume sequencer.
   assign resume_active = (rs_state_r != usb_link_pkg::RS_IDLE);

   // The synchronised line still shows our own K for two cycles after release.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         own_k_r <= 2'b00;
      end else begin
         own_k_r <= {own_k_r[0], !drive_oe_n_r};
      end
   end

   assign own_resume = resume_active || (own_k_r != 2'b00);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rs_state_r <= usb_link_pkg::RS_IDLE;
         rs_done_r <= 1'b0;
         rs_cnt_r <= '0;
         drive_oe_n_r <= 1'b1;
      end else begin
         if (!send_wake_r) begin
            rs_done_r <= 1'b0;
         end
         case (rs_state_r)
            usb_link_pkg::RS_IDLE: begin
               if (send_wake_r && rwe_r && !rs_done_r) begin
                  rs_state_r <= usb_link_pkg::RS_WAIT;
               end
            end
            usb_link_pkg::RS_WAIT: begin
               if (!rwe_r) begin
                  rs_state_r <= usb_link_pkg::RS_IDLE;
               end else if (!clk_stop_r && idle5) begin
                  rs_state_r <= usb_link_pkg::RS_DRIVE;
                  rs_cnt_r <= '0;
                  drive_oe_n_r <= 1'b0;
               end
            end
            usb_link_pkg::RS_DRIVE: begin
               if (rs_cnt_r == RW'(RESUME_CYC - 1)) begin
                  rs_state_r <= usb_link_pkg::RS_IDLE;
                  rs_done_r <= 1'b1;
                  drive_oe_n_r <= 1'b1;
               end else begin
                  rs_cnt_r <= rs_cnt_r + 1'b1;
               end
            end
            default: begin
               rs_state_r <= usb_link_pkg::RS_IDLE;
               drive_oe_n_r <= 1'b1;
            end
         endcase
      end
   end

   // Resume signalling is the K state.
   assign link.dev_dp = 1'b0;
   assign link.dev_dm = 1'b1;
   assign link.dev_oe_n = drive_oe_n_r;
endmodule

// >>> logic/usb_regs_map.svh
`ifndef USB_REGS_MAP_SVH
`define USB_REGS_MAP_SVH

// Register indexes; the byte address on the bus is four times the index.
`define IDX_CONTROL 8'hbc
`define IDX_FLAGS 8'hbd
`define IDX_ENABLES 8'hbe
`define IDX_FLAG_CLEAR 8'hbf
`define IDX_AUX 8'hc0

// Global control bit positions.
`define CTL_SEND_WAKE 5
`define CTL_DETACH 4
`define CTL_RESUME_ACTIVE 3
`define CTL_RWE 2
`define CTL_CONFIG 1
`define CTL_ADDR_EN 0

// Event flag and enable bit positions.
`define EV_WAKE 5
`define EV_EOR 4
`define EV_SOF 3
`define EV_SUSP 0
`define EV_MASK 8'h39

// Auxiliary register bit positions.
`define AUX_CLK_STOP 0
`define AUX_SUSPENDED 1
`define AUX_IN_RESET 2

// Reset values.
`define CONTROL_RESET 8'h00
`define FLAGS_RESET 8'h00
`define ENABLES_RESET 8'h10

// Token identifier of a start of frame.
`define PID_SOF 4'h5

// Timing.
`define CLK_PERIOD_NS 25
`define BUS_RESET_NS 2700
`define SUSPEND_US 3000
`define REMOTE_IDLE_US 5000
`define RESUME_US 2000
`define HOST_RESET_US 10000
`define SOF_DRIVE_CYC 4

`endif

// >>> logic/usb_link_pkg.sv
package usb_link_pkg;

   typedef enum logic [1:0] {
      LINE_SE0 = 2'b00,
      LINE_J = 2'b01,
      LINE_K = 2'b10,
      LINE_SE1 = 2'b11
   } line_t;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_RESET = 2'b01,
      H_SOF = 2'b10,
      H_RESUME = 2'b11
   } host_state_t;

   typedef enum logic [1:0] {
      RS_IDLE = 2'b00,
      RS_WAIT = 2'b01,
      RS_DRIVE = 2'b10
   } resume_state_t;

   // Full speed: J has D+ high, K has D- high.
   function automatic line_t line_of(input logic dp, input logic dm);
      line_t l;
      l = line_t'({dm, dp});
      return l;
   endfunction

endpackage

// >>> logic/usb_link_if.sv
`timescale 1ns/100ps
interface usb_link_if;
   logic dev_dp;
   logic dev_dm;
   logic dev_oe_n;
   logic vref;
   logic vref_oe_n;
   logic host_dp;
   logic host_dm;
   logic host_oe_n;
   logic tok_valid;
   logic [3:0] tok_pid;
   logic bus_dp;
   logic bus_dm;

   // An undriven line idles in J only while the pull-up reference is driven.
   assign bus_dp = !dev_oe_n ? dev_dp : (!host_oe_n ? host_dp : (!vref_oe_n && vref));
   assign bus_dm = !dev_oe_n ? dev_dm : (!host_oe_n ? host_dm : 1'b0);

   modport dev (
      input bus_dp, bus_dm, tok_valid, tok_pid,
      output dev_dp, dev_dm, dev_oe_n, vref, vref_oe_n
   );

   modport host (
      input bus_dp, bus_dm, vref, vref_oe_n,
      output host_dp, host_dm, host_oe_n, tok_valid, tok_pid
   );
endinterface

// >>> logic/condition_timer.sv
`timescale 1ns/100ps
module condition_timer #(
   parameter int LIMIT = 108
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cond_i,
   output logic reached_o
);
   localparam int W = $clog2(LIMIT + 1);
   logic [W-1:0] cnt_r;

   // Counts consecutive cycles of the condition and saturates at the limit.
   always_ff @(posedge clk_i) begin
      if (rst_i || !cond_i) begin
         cnt_r <= '0;
      end else if (cnt_r != W'(LIMIT)) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reached_o <= 1'b0;
      end else begin
         reached_o <= cond_i && (cnt_r >= W'(LIMIT - 1));
      end
   end
endmodule

// >>> logic/usb_host_end.sv
`include "usb_regs_map.svh"
`timescale 1ns/100ps
module usb_host_end #(
   parameter int HOST_RESET_CYC = `HOST_RESET_US * 1000 / `CLK_PERIOD_NS,
   parameter int RESUME_CYC = `RESUME_US * 1000 / `CLK_PERIOD_NS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic bus_reset_i,
   input wire logic sof_i,
   input wire logic resume_i,
   output logic busy_o,
   output logic attached_o,
   output logic remote_wake_o,
   usb_link_if.host link
);
   localparam int CW = $clog2(HOST_RESET_CYC + RESUME_CYC + 1);

   usb_link_pkg::host_state_t state_r;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] limit;
   logic [1:0] att_s_r;
   logic [1:0] dp_s_r;
   logic [1:0] dm_s_r;
   logic k_seen_r;
   logic k_now;
   logic oe_n_r;
   logic dp_r;
   logic dm_r;
   logic tok_valid_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         att_s_r <= 2'b00;
         dp_s_r <= 2'b00;
         dm_s_r <= 2'b00;
      end else begin
         att_s_r <= {att_s_r[0], link.vref && !link.vref_oe_n};
         dp_s_r <= {dp_s_r[0], link.bus_dp};
         dm_s_r <= {dm_s_r[0], link.bus_dm};
      end
   end

   assign k_now = (usb_link_pkg::line_of(dp_s_r[1], dm_s_r[1]) == usb_link_pkg::LINE_K);

   always_comb begin
      case (state_r)
         usb_link_pkg::H_RESET: limit = CW'(HOST_RESET_CYC - 1);
         usb_link_pkg::H_SOF: limit = CW'(`SOF_DRIVE_CYC - 1);
         usb_link_pkg::H_RESUME: limit = CW'(RESUME_CYC - 1);
         default: limit = '0;
      endcase
   end

   // Requests are taken only while idle; reset has the highest priority.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= usb_link_pkg::H_IDLE;
         cnt_r <= '0;
         oe_n_r <= 1'b1;
         dp_r <= 1'b0;
         dm_r <= 1'b0;
         tok_valid_r <= 1'b0;
      end else begin
         tok_valid_r <= 1'b0;
         case (state_r)
            usb_link_pkg::H_IDLE: begin
               cnt_r <= '0;
               if (bus_reset_i) begin
                  state_r <= usb_link_pkg::H_RESET;
                  oe_n_r <= 1'b0;
                  dp_r <= 1'b0;
                  dm_r <= 1'b0;
               end else if (sof_i) begin
                  state_r <= usb_link_pkg::H_SOF;
                  oe_n_r <= 1'b0;
                  dp_r <= 1'b0;
                  dm_r <= 1'b1;
                  tok_valid_r <= 1'b1;
               end else if (resume_i) begin
                  state_r <= usb_link_pkg::H_RESUME;
                  oe_n_r <= 1'b0;
                  dp_r <= 1'b0;
                  dm_r <= 1'b1;
               end
            end
            usb_link_pkg::H_RESET, usb_link_pkg::H_SOF, usb_link_pkg::H_RESUME: begin
               if (cnt_r == limit) begin
                  state_r <= usb_link_pkg::H_IDLE;
                  oe_n_r <= 1'b1;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            default: begin
               state_r <= usb_link_pkg::H_IDLE;
               oe_n_r <= 1'b1;
            end
         endcase
      end
   end

   // A K state seen while the host is silent is a remote wake.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         k_seen_r <= 1'b0;
         remote_wake_o <= 1'b0;
         attached_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         k_seen_r <= k_now && oe_n_r;
         remote_wake_o <= k_now && oe_n_r && !k_seen_r;
         attached_o <= att_s_r[1];
         busy_o <= (state_r != usb_link_pkg::H_IDLE) || bus_reset_i || sof_i || resume_i;
      end
   end

   assign link.host_dp = dp_r;
   assign link.host_dm = dm_r;
   assign link.host_oe_n = oe_n_r;
   assign link.tok_valid = tok_valid_r;
   assign link.tok_pid = `PID_SOF;
endmodule

// >>> test/usb_global_ctrl_irq_regs_asserts.sv
`timescale 1ns/100ps
`include "usb_regs_map.svh"
module usb_global_ctrl_irq_regs_asserts #(
   parameter int REMOTE_IDLE_CYC = 200000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic dev_dp,
   input wire logic dev_dm,
   input wire logic dev_oe_n,
   input wire logic vref,
   input wire logic vref_oe_n,
   input wire logic host_dp,
   input wire logic host_dm,
   input wire logic host_oe_n,
   input wire logic tok_valid,
   input wire logic [3:0] tok_pid,
   input wire logic bus_dp,
   input wire logic bus_dm
);
   int j_cnt;

   // Counts consecutive idle J cycles seen on the resolved line.
   always_ff @(posedge clk_i) begin
      if (rst_i || !(bus_dp && !bus_dm)) begin
         j_cnt <= 0;
      end else if (j_cnt < REMOTE_IDLE_CYC) begin
         j_cnt <= j_cnt + 1;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence sof_k_s;
      (!host_oe_n && host_dm && !host_dp) [*4];
   endsequence

   sequence resume_k_s;
      (!dev_oe_n && dev_dm && !dev_dp) [*8];
   endsequence

   chk_tok_pid_sof: assert property (tok_valid |-> tok_pid == `PID_SOF)
      else $error("token pid is not start of frame");
   chk_tok_one_pulse: assert property (tok_valid |=> !tok_valid)
      else $error("token valid longer than one cycle");
   chk_sof_k_drive: assert property (tok_valid |-> sof_k_s ##[1:2] host_oe_n)
      else $error("start of frame drive has wrong shape");
   chk_resume_k_level: assert property (!dev_oe_n |-> !dev_dp && dev_dm)
      else $error("device drives something other than K");
   chk_resume_min_len: assert property ($fell(dev_oe_n) |-> resume_k_s)
      else $error("upstream resume too short");
   chk_resume_after_idle: assert property ($fell(dev_oe_n) |-> j_cnt >= REMOTE_IDLE_CYC)
      else $error("upstream resume before enough idle time");
   chk_vref_drive_high: assert property (!vref_oe_n |-> vref)
      else $error("pull-up reference driven low");
   chk_reset_release: assert property ($fell(rst_i) |->
      !vref_oe_n && dev_oe_n && host_oe_n && !tok_valid)
      else $error("line drivers wrong after reset");
endmodule

// >>> test/usb_global_ctrl_irq_regs_bench.sv
`timescale 1ns/100ps
`include "usb_regs_map.svh"
`define CHECK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end
module usb_global_ctrl_irq_regs_bench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o, rdata;
   logic wb_ack_o, irq_o, busy_o, attached_o, remote_wake_o;
   logic bus_reset_i = 1'b0, sof_i = 1'b0, resume_i = 1'b0;
   int num_errors = 0, num_checks = 0, cycles = 0, n;
   usb_link_if link ();
   usb_device_end #(.SUSPEND_CYC(200), .REMOTE_IDLE_CYC(300), .RESUME_CYC(50)) i_usb_device_end (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .link(link));
   usb_host_end #(.HOST_RESET_CYC(150), .RESUME_CYC(50)) i_usb_host_end (
      .clk_i(clk_i), .rst_i(rst_i), .bus_reset_i(bus_reset_i), .sof_i(sof_i),
      .resume_i(resume_i), .busy_o(busy_o), .attached_o(attached_o),
      .remote_wake_o(remote_wake_o), .link(link));
   usb_global_ctrl_irq_regs_asserts #(.REMOTE_IDLE_CYC(300)) i_usb_global_ctrl_irq_regs_asserts (
      .clk_i(clk_i), .rst_i(rst_i), .dev_dp(link.dev_dp), .dev_dm(link.dev_dm),
      .dev_oe_n(link.dev_oe_n), .vref(link.vref), .vref_oe_n(link.vref_oe_n),
      .host_dp(link.host_dp), .host_dm(link.host_dm), .host_oe_n(link.host_oe_n),
      .tok_valid(link.tok_valid), .tok_pid(link.tok_pid), .bus_dp(link.bus_dp),
      .bus_dm(link.bus_dm));

   always #12.5 clk_i = ~clk_i;

   task automatic complete_run;
      if (num_errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         complete_run();
      end
   end

   // One classic Wishbone cycle; entered just after a rising edge.
   task automatic wb_cycle(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                           input logic [3:0] sel, output logic [31:0] rd);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {2'b00, idx, 2'b00};
      wb_sel_i <= sel;
      wb_dat_i <= {24'h00_0000, wd};
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] t;
      wb_cycle(1'b1, idx, d, 4'h1, t);
   endtask

   task automatic rd(input logic [7:0] idx);
      wb_cycle(1'b0, idx, 8'h00, 4'h1, rdata);
   endtask

   // Pulses one host request (reset, frame start, resume) and waits for the host to finish.
   task automatic host_req(input logic [2:0] r);
      {bus_reset_i, sof_i, resume_i} <= r;
      @(posedge clk_i);
      {bus_reset_i, sof_i, resume_i} <= 3'b000;
      repeat (2) @(posedge clk_i);
      for (n = 0; n < 1000 && busy_o !== 1'b0; n++) @(posedge clk_i);
   endtask

   task automatic t_reset_values;
      rd(`IDX_CONTROL);
      `CHECK(rdata, 32'h0000_0000);
      rd(`IDX_FLAGS);
      `CHECK(rdata[7:0], 8'h00);
      rd(`IDX_ENABLES);
      `CHECK(rdata[7:0], 8'h10);
      rd(8'h10);
      `CHECK(rdata, 32'h0000_0000);
      `CHECK(irq_o, 1'b0);
   endtask

   task automatic t_control_reset;
      wr(`IDX_CONTROL, 8'h07);
      rd(`IDX_CONTROL);
      `CHECK(rdata[7:0], 8'h07);
      wb_cycle(1'b1, `IDX_CONTROL, 8'h00, 4'he, rdata);
      rd(`IDX_CONTROL);
      `CHECK(rdata[7:0], 8'h07);
      wr(`IDX_CONTROL, 8'hc8);
      rd(`IDX_CONTROL);
      `CHECK(rdata[7:0], 8'h01);
      wr(`IDX_CONTROL, 8'h10);
      @(posedge clk_i);
      `CHECK(link.vref_oe_n, 1'b1);
      for (n = 0; n < 20 && attached_o !== 1'b0; n++) @(posedge clk_i);
      `CHECK(attached_o, 1'b0);
      wr(`IDX_CONTROL, 8'h00);
      @(posedge clk_i);
      `CHECK(link.vref_oe_n, 1'b0);
      `CHECK(link.vref, 1'b1);
      wr(`IDX_CONTROL, 8'h03);
      host_req(3'b100);
      repeat (4) @(posedge clk_i);
      rd(`IDX_CONTROL);
      `CHECK(rdata[7:0], 8'h00);
      `CHECK(irq_o, 1'b1);
      rd(`IDX_FLAGS);
      `CHECK(rdata[4], 1'b1);
   endtask

   task automatic t_frame_start;
      wr(`IDX_FLAG_CLEAR, 8'hff);
      wr(`IDX_ENABLES, 8'hff);
      rd(`IDX_ENABLES);
      `CHECK(rdata[7:0], 8'h39);
      wr(`IDX_ENABLES, 8'h08);
      @(posedge clk_i);
      `CHECK(irq_o, 1'b0);
      host_req(3'b010);
      repeat (20) @(posedge clk_i);
      `CHECK(irq_o, 1'b1);
      rd(`IDX_FLAGS);
      `CHECK(rdata[3], 1'b1);
      wr(`IDX_FLAG_CLEAR, 8'h08);
      @(posedge clk_i);
      `CHECK(irq_o, 1'b0);
   endtask

   task automatic t_suspend_wake;
      logic [7:0] exp_f;
      exp_f = 8'h21;
      wr(`IDX_FLAG_CLEAR, 8'hff);
      wr(`IDX_ENABLES, 8'h01);
      for (n = 0; n < 600 && irq_o !== 1'b1; n++) @(posedge clk_i);
      rd(`IDX_FLAGS);
      `CHECK(rdata[7:0], 8'h01);
      host_req(3'b001);
      rd(`IDX_FLAGS);
      `CHECK(rdata[7:0], exp_f);
      for (int i = 0; i < 8; i++) begin
         wr(`IDX_ENABLES, 8'h01 << i);
         @(posedge clk_i);
         `CHECK(irq_o, exp_f[i]);
      end
      wr(`IDX_AUX, 8'h00);
      wr(`IDX_FLAGS, 8'hde);
      rd(`IDX_FLAGS);
      `CHECK(rdata[7:0], 8'h00);
   endtask

   task automatic t_remote_wake;
      wr(`IDX_CONTROL, 8'h20);
      rd(`IDX_CONTROL);
      `CHECK(rdata[7:0], 8'h20);
      wr(`IDX_CONTROL, 8'h00);
      wr(`IDX_CONTROL, 8'h04);
      wr(`IDX_CONTROL, 8'h24);
      rd(`IDX_CONTROL);
      `CHECK(rdata[7:0], 8'h2c);
      for (n = 0; n < 1000 && remote_wake_o !== 1'b1; n++) @(posedge clk_i);
      `CHECK(remote_wake_o, 1'b1);
      for (n = 0; n < 200 && link.dev_oe_n !== 1'b1; n++) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
      rd(`IDX_CONTROL);
      `CHECK(rdata[7:0], 8'h24);
      rd(`IDX_FLAGS);
      `CHECK(rdata[5], 1'b0);
   endtask

   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset_values();
      t_control_reset();
      t_frame_start();
      t_suspend_wake();
      t_remote_wake();
      complete_run();
   end
endmodule
